// ### tb/adc_spi_command_decoder_tb.sv
/*
 Self-checking bench of the command decoder: command table, register
 read/write, reset paths, sample clipping, two-deep buffer and sync.
 Assumes the design package and the host model are compiled first.
*/
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module adc_spi_command_decoder_tb;
	import adcsd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] MS = 16'hFBFF;
	localparam int SETTLE_CYC = 50; // register_settle_time, arbitrary
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic sync_n = 1'b1;
	logic sv = 1'b0;
	adcsd_sample_t smp = '0;
	adcsd_sample_t sa;
	adcsd_sample_t sb;
	logic sclk, cs_n, din, dout, data_ready_n_n, srdy, stby, lck;
	int failures = 0;
	int num_checks = 0;
	int rises = 0;
	logic [15:0] prev;
	// lock taken in standby must leave standby alone
	logic [15:0] cq [7] = '{CMD_STANDBY, CMD_STANDBY, CMD_LOCK, CMD_WAKE,
		CMD_UNLOCK, CMD_WAKE, CMD_WAKE};
	logic [15:0] rq [7] = '{16'h0022, 16'h0022, 16'h0555, 16'h8100,
		16'h0655, 16'h0033, 16'h0033};
	logic [6:0] sbv = 7'b0011111;
	logic [6:0] lbv = 7'b0001100;
	always #10 clk_i = ~clk_i;
	always @(posedge data_ready_n_n) rises++;
	adcsd_core dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .din_i(din), .sync_reset_n_i(sync_n),
		.sample_i(smp), .sample_valid_i(sv), .sample_ready_o(srdy),
		.dout_o(dout), .data_ready_n_o(data_ready_n_n), .standby_o(stby),
		.locked_o(lck));
	adcsd_host host_u (.clk_i(clk_i), .dout_i(dout), .sclk_o(sclk),
		.cs_n_o(cs_n), .din_o(din));
	function automatic logic [23:0] clip(input logic signed [25:0] r);
		if (r >= RAW_MAX) return CODE_MAX;
		if (r <= RAW_MIN) return CODE_MIN;
		return r[23:0];
	endfunction : clip
	function automatic logic [15:0] stat(input logic l, input logic [3:0] r);
		return {l, 4'h0, 1'b0, 2'h1, 4'h0, r};
	endfunction : stat
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic xfer(input logic [15:0] c, d1, exp, m, input int nw);
		host_u.tx[0] = {c, 8'h00};
		host_u.tx[1] = {d1, 8'h00};
		for (int i = 2; i < 8; i++) host_u.tx[i] = 24'h000000;
		host_u.frame(nw);
		`CHK(host_u.rx[0][23:8] & m, exp & m)
		`CHK(host_u.rx[0][7:0], 8'h00)
	endtask : xfer
	task automatic push(input adcsd_sample_t s);
		int n;
		@(posedge clk_i) #1 smp = s;
		sv = 1'b1;
		for (n = 0; n < 100 && srdy !== 1'b1; n++) @(posedge clk_i) #1;
		if (n == 100) begin
			failures++;
			give_verdict();
		end
		@(posedge clk_i) #1 sv = 1'b0;
	endtask : push
	task automatic chk_codes(input adcsd_sample_t s);
		for (int c = 0; c < NCH; c++) `CHK(host_u.rx[c + 1], clip(s.ch[c]))
	endtask : chk_codes
	initial begin
		void'($urandom(70));
		repeat (12) @(posedge clk_i);
		#1 rst_b_i = 1'b1;
		repeat (2) @(posedge clk_i);
		xfer(CMD_NULL, 16'h0, 16'h0, 16'h0, 6);
		xfer(16'h1234, 16'h0, stat(0, 4'h0), MS, 6);
		xfer(16'h0023, 16'h0, stat(0, 4'h0), MS, 6);
		prev = stat(0, 4'h0);
		for (int i = 0; i < 7; i++) begin
			xfer(cq[i], 16'h0, prev, MS, 6);
			prev = rq[i];
			`CHK(stby, sbv[i])
			`CHK(lck, lbv[i])
		end
		$display("command table done");
		xfer(16'hA100, 16'h0, prev, MS, 6);
		xfer(16'h6180, 16'h1234, MODE_RST, 16'hFFFF, 6);
		xfer(16'hA181, 16'h0, 16'h4180, 16'hFFFF, 6);
		xfer(CMD_NULL, 16'h0, 16'hE181, 16'hFFFF, 6);
		`CHK(host_u.rx[1], 24'h123400)
		`CHK(host_u.rx[2], 24'h000000)
		xfer(CMD_RESET, 16'h0, 16'h0, 16'h0, 2);
		xfer(16'hA180, 16'h0, RESP_RESET_BAD, 16'hFFFF, 6);
		xfer(CMD_RESET, 16'h0, 16'h1234, 16'hFFFF, 6);
		repeat (SETTLE_CYC) @(posedge clk_i);
		xfer(16'hA180, 16'h0, RESP_RESET_OK, 16'hFFFF, 6);
		xfer(CMD_NULL, 16'h0, CFG_RST, 16'hFFFF, 6);
		$display("register and reset done");
		sa.ch = {26'h0000001, 26'h3FFFFFF, 26'h3800000, 26'h07FFFFF};
		sb.ch[3] = 26'h1FFFFFF;
		sb.ch[2] = 26'h2000000;
		sb.ch[1] = 26'h0;
		sb.ch[0] = 26'($urandom());
		push(sa);
		push(sb);
		repeat (4) @(posedge clk_i);
		`CHK(srdy, 1'b0)
		`CHK(data_ready_n_n, 1'b0)
		rises = 0;
		// two reads back to back drain the buffer
		xfer(CMD_NULL, 16'h0, 16'h0, 16'h8000, 6);
		chk_codes(sa);
		`CHK(data_ready_n_n, 1'b0)
		`CHK(rises > 0, 1'b1)
		xfer(CMD_NULL, 16'h0, stat(0, 4'hF), MS, 6);
		chk_codes(sb);
		`CHK(data_ready_n_n, 1'b1)
		`CHK(srdy, 1'b1)
		$display("buffer done");
		sa.ch[0] = 26'($urandom());
		push(sa);
		@(posedge clk_i) #1 sync_n = 1'b0;
		repeat (3) @(posedge clk_i);
		#1 sync_n = 1'b1;
		repeat (6) @(posedge clk_i);
		`CHK(data_ready_n_n, 1'b1)
		`CHK(srdy, 1'b1)
		$display("sync done");
		// switch the ready signal to its pulse format
		xfer(16'h6100, 16'h0511, stat(0, 4'h0), MS, 6);
		xfer(CMD_NULL, 16'h0, 16'h4100, 16'hFFFF, 6);
		push(sa);
		`CHK(data_ready_n_n, 1'b0)
		repeat (PULSE_CYC) @(posedge clk_i);
		#1;
		`CHK(data_ready_n_n, 1'b1)
		$display("pulse format done");
		give_verdict();
	end
endmodule : adc_spi_command_decoder_tb

// ### tb/adcsd_host.sv
/*
 Host controller model for the serial link: runs frames of 24-bit words,
 MSB first, sclk idle low, 160 ns link period.
 Assumes the bench loads tx before calling frame and reads rx afterwards.
*/
module adcsd_host (
	input wire logic clk_i,
	input wire logic dout_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] tx [8];
	logic [23:0] rx [8];
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end
	// nw below six gives a cut-short frame
	task automatic frame(input int nw);
		@(posedge clk_i) #1 cs_n_o = 1'b0;
		repeat (4) @(posedge clk_i);
		for (int w = 0; w < nw; w++) begin
			for (int b = 23; b >= 0; b--) begin
				@(posedge clk_i) #1 din_o = tx[w][b];
				sclk_o = 1'b1;
				repeat (4) @(posedge clk_i);
				#1 sclk_o = 1'b0;
				rx[w][b] = dout_i;
				repeat (3) @(posedge clk_i);
			end
		end
		repeat (2) @(posedge clk_i);
		#1 cs_n_o = 1'b1;
		// released line must not hold its last value
		din_o = ~din_o;
		repeat (6) @(posedge clk_i);
	endtask : frame
endmodule : adcsd_host

// ### verilog/adcsd_core.sv
/*
 Serial command decoder and conversion data output path of a
 four-channel converter: code clipping, two-deep per-channel buffer,
 ready signalling, command decode and next-frame responses.
 Assumes sclk/cs/din/sync pins are asynchronous to clk_i and slow enough
 (sclk period of several clk_i cycles) to be sampled; samples arrive
 from logic on clk_i.
*/
// Functional notes
// - inputs beyond full scale clip to 7FFFFF or 800000.
// - results are 24-bit two's complement codes.
// - output buffer holds two samples of every channel.
// - channel ready flags stay set until both buffered samples are read.
// - sync/reset strobe resynchronizes and empties the output buffers.
// - level format gives a brief ready pulse after first set shifted out.
// - each command is answered in the following frame.
// - no-operation changes nothing and answers with the status word.
// - unknown command words act as no-operation.
// - reset latched at frame end restores register defaults at once.
// - completed reset answers FF24h next frame.
// - reset with an incomplete frame does nothing, answers 0011h.
// - standby latched at frame end, echoes its word, idempotent.
// - wake returns to converting, echoes its word, idempotent.
// - lock guards the interface; only no-op, read, unlock act.
// - a guarded interface keeps converting and sending data.
// - unlock releases the guard and echoes its word.
// - register read: one value alone, or 111 header then data.
// - register write answers 010 header with count written minus one.
// - a frame is six words: response, four channels, check word (not generated, reads as zero).
// - 16-bit words sit MSB aligned with zero low bits.
module adcsd_core (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	input wire logic sync_reset_n_i,
	input wire adcsd_pkg::adcsd_sample_t sample_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	output logic dout_o,
	output logic data_ready_n_o,
	output logic standby_o,
	output logic locked_o
);
	import adcsd_pkg::*;

	adcsd_state_t st;
	adcsd_state_t next_st;

	logic sclk_rise;
	logic sclk_fall;
	logic word_done;
	logic frame_end;
	logic frame_full;
	logic sync_fall;
	logic push;
	logic pop;
	logic [WORD_W-1:0] in_word;
	logic [15:0] status_word;

	assign sclk_rise = st.in_frame & st.sclk_s2 & ~st.sclk_d;
	assign sclk_fall = st.in_frame & ~st.sclk_s2 & st.sclk_d;
	assign word_done = sclk_fall && (st.bit_cnt == BIT_LAST);
	assign frame_end = st.in_frame & st.cs_s2;
	assign frame_full = st.word_cnt >= FRAME_WORDS;
	assign sync_fall = ~st.sync_s2 & st.sync_d;
	assign in_word = {st.shift_in[WORD_W-2:0], st.din_s2};
	assign push = sample_valid_i & st.rdy;
	// the buffer head leaves once the last channel word is through
	assign pop = word_done && (st.word_cnt == LAST_CH_WORD) &&
		!st.multi_rd && (st.count != 2'h0);

	// all four ready flags follow the shared buffer fill
	assign status_word = {st.locked, 4'h0, st.reset_flag, WLEN_24,
		4'h0, {NCH{st.count != 2'h0}}};

	function automatic logic [WORD_W-1:0] clip(
		input logic [RAW_W-1:0] raw
	);
		logic signed [RAW_W-1:0] s;
		s = signed'(raw);
		if (s >= RAW_MAX) begin
			return CODE_MAX;
		end else if (s <= RAW_MIN) begin
			return CODE_MIN;
		end
		return raw[WORD_W-1:0];
	endfunction : clip

	function automatic logic [15:0] reg_value(input logic [5:0] addr);
		logic [5:0] idx;
		idx = addr - ADDR_MODE;
		if (addr == ADDR_ID) begin
			return ID_VALUE;
		end else if (addr == ADDR_STATUS) begin
			return status_word;
		end else if (addr < ADDR_END) begin
			return st.cfg[idx[2:0]];
		end
		return 16'h0000;
	endfunction : reg_value

	function automatic logic [WORD_W-1:0] out_word(input logic [7:0] w);
		logic [7:0] k;
		k = w - 8'h01;
		if (st.multi_rd) begin
			if (w == 8'h00) begin
				return {RD_HDR, st.rd_addr, st.rd_cnt, 8'h00};
			end else if (k <= {1'b0, st.rd_cnt}) begin
				return {reg_value(st.rd_addr + k[5:0]), 8'h00};
			end
			return '0;
		end
		if (w == 8'h00) begin
			return {st.resp_sel ? status_word : st.resp_word, 8'h00};
		end else if (w <= LAST_CH_WORD) begin
			return st.mem[st.rptr][k[1:0]];
		end
		// check word is not generated and reads as zero
		return '0;
	endfunction : out_word

	always_comb begin
		logic [WORD_W-1:0] w;
		logic [15:0] c;
		logic [5:0] idx;
		logic trig;
		w = '0;
		c = st.cmd;
		idx = st.wr_addr - ADDR_MODE;
		trig = 1'b0;
		next_st = st;

		next_st.sclk_s1 = sclk_i;
		next_st.sclk_s2 = st.sclk_s1;
		next_st.sclk_d = st.sclk_s2;
		next_st.cs_s1 = cs_n_i;
		next_st.cs_s2 = st.cs_s1;
		next_st.din_s1 = din_i;
		next_st.din_s2 = st.din_s1;
		next_st.sync_s1 = sync_reset_n_i;
		next_st.sync_s2 = st.sync_s1;
		next_st.sync_d = st.sync_s2;

		if (!st.cs_s2 && !st.in_frame) begin
			next_st.in_frame = 1'b1;
			next_st.bit_cnt = 5'h00;
			next_st.word_cnt = 8'h00;
		end

		// data changes on the rising edge, host samples on the falling one
		if (sclk_rise) begin
			if (st.bit_cnt == 5'h00) begin
				w = out_word(st.word_cnt);
				next_st.dout = w[WORD_W-1];
				next_st.shift_out = {w[WORD_W-2:0], 1'b0};
			end else begin
				next_st.dout = st.shift_out[WORD_W-1];
				next_st.shift_out = {st.shift_out[WORD_W-2:0], 1'b0};
			end
		end

		if (sclk_fall) begin
			next_st.shift_in = in_word;
			next_st.bit_cnt = st.bit_cnt + 5'h01;
		end

		if (word_done) begin
			next_st.bit_cnt = 5'h00;
			if (st.word_cnt != 8'hFF) begin
				next_st.word_cnt = st.word_cnt + 8'h01;
			end
			if (st.word_cnt == 8'h00) begin
				next_st.cmd = in_word[WORD_W-1:8];
				next_st.wr_left = 8'h00;
				if (in_word[23:21] == WR_PFX && !st.locked) begin
					next_st.wr_base = in_word[20:15];
					next_st.wr_addr = in_word[20:15];
					next_st.wr_left = {1'b0, in_word[14:8]} + 8'h01;
					next_st.wr_num = 7'h00;
				end
			end else if (st.wr_left != 8'h00) begin
				// words land as they arrive; read-only or absent slots skip
				if (st.wr_addr >= ADDR_MODE && st.wr_addr < ADDR_END) begin
					next_st.cfg[idx[2:0]] = in_word[WORD_W-1:8];
					next_st.wr_num = st.wr_num + 7'h01;
				end
				next_st.wr_addr = st.wr_addr + 6'h01;
				next_st.wr_left = st.wr_left - 8'h01;
			end
		end

		// commands act at frame end and answer in the next frame
		if (frame_end) begin
			next_st.in_frame = 1'b0;
			next_st.dout = 1'b0;
			next_st.multi_rd = 1'b0;
			next_st.resp_sel = 1'b1;
			if (st.resp_sel) begin
				next_st.reset_flag = 1'b0;
			end
			if (c[15:13] == RD_PFX) begin
				if (c[6:0] == 7'h00) begin
					next_st.resp_word = reg_value(c[12:7]);
					next_st.resp_sel = 1'b0;
				end else begin
					next_st.multi_rd = 1'b1;
					next_st.rd_addr = c[12:7];
					next_st.rd_cnt = c[6:0];
				end
			end else if (c == CMD_UNLOCK) begin
				next_st.locked = 1'b0;
				next_st.resp_word = c;
				next_st.resp_sel = 1'b0;
			end else if (!st.locked) begin
				if (c == CMD_RESET) begin
					next_st.resp_sel = 1'b0;
					if (frame_full) begin
						next_st.cfg = '0;
						next_st.cfg[0] = MODE_RST;
						next_st.locked = 1'b0;
						next_st.standby = 1'b0;
						next_st.reset_flag = 1'b1;
						next_st.resp_word = RESP_RESET_OK;
					end else begin
						next_st.resp_word = RESP_RESET_BAD;
					end
				end else if (c == CMD_STANDBY || c == CMD_WAKE) begin
					next_st.standby = (c == CMD_STANDBY);
					next_st.resp_word = c;
					next_st.resp_sel = 1'b0;
				end else if (c == CMD_LOCK) begin
					// locking must not wake a device held in standby
					next_st.locked = 1'b1;
					next_st.resp_word = c;
					next_st.resp_sel = 1'b0;
				end else if (c[15:13] == WR_PFX) begin
					next_st.resp_word = {WR_ACK, st.wr_base,
						st.wr_num - 7'h01};
					next_st.resp_sel = 1'b0;
				end
			end
		end

		// buffer: strobe empties it, a fresh sample may still enter after
		if (sync_fall || (frame_end && c == CMD_RESET && frame_full &&
				!st.locked)) begin
			next_st.count = 2'h0;
			next_st.rptr = 1'b0;
			next_st.wptr = 1'b0;
		end else if (pop) begin
			next_st.count = st.count - 2'h1;
			next_st.rptr = ~st.rptr;
			trig = ~st.cfg[0][FMT_BIT] && (st.count == 2'h2) && !push;
		end
		if (push) begin
			for (int i = 0; i < NCH; i++) begin
				next_st.mem[next_st.wptr][i] = clip(sample_i.ch[i]);
			end
			next_st.wptr = ~next_st.wptr;
			next_st.count = next_st.count + 2'h1;
			trig = trig | st.cfg[0][FMT_BIT];
		end
		// conversions keep flowing while guarded, halt in standby or while the buffer is full
		next_st.rdy = (next_st.count != 2'h2) && !next_st.standby;

		if (st.pulse_cnt != 3'h0) begin
			next_st.pulse_cnt = st.pulse_cnt - 3'h1;
		end
		if (trig) begin
			next_st.pulse_cnt = next_st.cfg[0][FMT_BIT] ? PULSE_CYC : BRIEF_CYC;
		end
		if (next_st.cfg[0][FMT_BIT]) begin
			next_st.data_ready_n_n = (next_st.pulse_cnt == 3'h0);
		end else begin
			next_st.data_ready_n_n = (next_st.count == 2'h0) ||
				(next_st.pulse_cnt != 3'h0);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= '0;
			st.cfg[0] <= MODE_RST;
			st.reset_flag <= 1'b1;
			st.cs_s1 <= 1'b1;
			st.cs_s2 <= 1'b1;
			st.sync_s1 <= 1'b1;
			st.sync_s2 <= 1'b1;
			st.sync_d <= 1'b1;
			st.resp_sel <= 1'b1;
			st.rdy <= 1'b1;
			st.data_ready_n_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign sample_ready_o = st.rdy;
	assign dout_o = st.dout;
	assign data_ready_n_o = st.data_ready_n_n;
	assign standby_o = st.standby;
	assign locked_o = st.locked;

	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	clip_high_a: assert property (
		push && $signed(sample_i.ch[0]) >= RAW_MAX
		|=> st.mem[$past(st.wptr)][0] == CODE_MAX)
		else $error("positive overrange not clipped");

	clip_low_a: assert property (
		push && $signed(sample_i.ch[1]) <= RAW_MIN
		|=> st.mem[$past(st.wptr)][1] == CODE_MIN)
		else $error("negative overrange not clipped");

	code_pass_a: assert property (
		push && $signed(sample_i.ch[2]) < RAW_MAX &&
		$signed(sample_i.ch[2]) > RAW_MIN
		|=> st.mem[$past(st.wptr)][2] == $past(sample_i.ch[2][23:0]))
		else $error("in-range code altered");

	fifo_depth_a: assert property (
		st.count == 2'h2 |-> !sample_ready_o)
		else $error("full buffer still accepts samples");

	flag_hold_a: assert property (
		pop && st.count == 2'h2 && !sync_fall
		|=> status_word[NCH-1:0] == 4'hF && st.count == 2'h1)
		else $error("ready flags dropped with one sample left");

	sync_clear_a: assert property (
		sync_fall && !push |=> st.count == 2'h0 ##1 data_ready_n_o)
		else $error("sync strobe did not empty buffer");

	brief_pulse_a: assert property (
		pop && st.count == 2'h2 && !push && !sync_fall &&
		!st.cfg[0][FMT_BIT] |=> data_ready_n_o ##1 !data_ready_n_o)
		else $error("brief ready pulse missing");

	reset_ack_a: assert property (
		frame_end && st.cmd == CMD_RESET && frame_full && !st.locked
		|=> st.resp_word == RESP_RESET_OK && st.cfg[0] == MODE_RST &&
		!st.resp_sel)
		else $error("reset not acknowledged");

	reset_short_a: assert property (
		frame_end && st.cmd == CMD_RESET && !frame_full && !st.locked
		|=> st.resp_word == RESP_RESET_BAD && $stable(st.cfg))
		else $error("short reset frame acted");

	guard_hold_a: assert property (
		frame_end && st.locked && st.cmd != CMD_UNLOCK
		|=> locked_o && $stable(standby_o))
		else $error("guarded interface changed state");

	lock_enter_a: assert property (
		frame_end && !st.locked && st.cmd == CMD_LOCK
		|=> locked_o && $stable(standby_o))
		else $error("lock altered standby state");

endmodule : adcsd_core

// ### verilog/adcsd_pkg.sv
/*
 Shared constants and carrier types of the converter's serial command
 decoder and conversion data output path.
 Assumes a single 50 MHz system clock and a 24-bit serial word size.
*/
package adcsd_pkg;

	localparam int NCH = 4;
	localparam int WORD_W = 24;
	localparam int SIG_W = 16;
	localparam int RAW_W = 26;
	localparam int FIFO_DEPTH = 2;
	localparam int NREG = 8;
	localparam int NCFG = 6;
	localparam logic [7:0] FRAME_WORDS = 8'h06;
	localparam logic [7:0] LAST_CH_WORD = 8'h04;
	localparam logic [4:0] BIT_LAST = 5'h17;

	// command words, compared over all 16 significant bits
	localparam logic [15:0] CMD_NULL = 16'h0000;
	localparam logic [15:0] CMD_RESET = 16'h0011;
	localparam logic [15:0] CMD_STANDBY = 16'h0022;
	localparam logic [15:0] CMD_WAKE = 16'h0033;
	localparam logic [15:0] CMD_LOCK = 16'h0555;
	localparam logic [15:0] CMD_UNLOCK = 16'h0655;
	localparam logic [2:0] RD_PFX = 3'h5;
	localparam logic [2:0] WR_PFX = 3'h3;
	localparam logic [2:0] RD_HDR = 3'h7;
	localparam logic [2:0] WR_ACK = 3'h2;
	localparam logic [15:0] RESP_RESET_OK = 16'hFF24;
	localparam logic [15:0] RESP_RESET_BAD = 16'h0011;

	// register map
	localparam logic [5:0] ADDR_ID = 6'h00;
	localparam logic [5:0] ADDR_STATUS = 6'h01;
	localparam logic [5:0] ADDR_MODE = 6'h02;
	localparam logic [5:0] ADDR_END = 6'h08;
	localparam logic [15:0] ID_VALUE = 16'h5A00; // arbitrary value
	localparam logic [15:0] STATUS_RST = 16'h0500;
	localparam logic [15:0] MODE_RST = 16'h0510;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam int FMT_BIT = 0;
	localparam logic [1:0] WLEN_24 = 2'h1;

	// output code limits
	localparam logic [WORD_W-1:0] CODE_MAX = 24'h7FFFFF;
	localparam logic [WORD_W-1:0] CODE_MIN = 24'h800000;
	localparam logic signed [RAW_W-1:0] RAW_MAX = 26'sh07FFFFF;
	localparam logic signed [RAW_W-1:0] RAW_MIN = 26'sh3800000;

	// ready signal timing
	localparam int CLK_NS = 20;
	localparam int BRIEF_NS = 20;
	localparam int PULSE_NS = 80;
	localparam logic [2:0] BRIEF_CYC =
		3'((BRIEF_NS / CLK_NS) > 0 ? BRIEF_NS / CLK_NS : 1);
	localparam logic [2:0] PULSE_CYC = 3'((PULSE_NS + CLK_NS - 1) / CLK_NS);

	typedef struct packed {
		logic [NCH-1:0][RAW_W-1:0] ch;
	} adcsd_sample_t;

	typedef struct packed {
		logic sclk_s1, sclk_s2, sclk_d;
		logic cs_s1, cs_s2, din_s1, din_s2;
		logic sync_s1, sync_s2, sync_d;
		logic in_frame;
		logic [4:0] bit_cnt;
		logic [7:0] word_cnt;
		logic [WORD_W-1:0] shift_in;
		logic [WORD_W-1:0] shift_out;
		logic dout;
		logic [15:0] cmd;
		logic [15:0] resp_word;
		logic resp_sel;
		logic multi_rd;
		logic [5:0] rd_addr;
		logic [6:0] rd_cnt;
		logic [5:0] wr_base;
		logic [5:0] wr_addr;
		logic [7:0] wr_left;
		logic [6:0] wr_num;
		logic [NCFG-1:0][15:0] cfg;
		logic [FIFO_DEPTH-1:0][NCH-1:0][WORD_W-1:0] mem;
		logic wptr, rptr;
		logic [1:0] count;
		logic rdy;
		logic locked, standby, reset_flag;
		logic [2:0] pulse_cnt;
		logic data_ready_n_n;
	} adcsd_state_t;

endpackage : adcsd_pkg
